// ---- hdl/mec_pkg.sv ----
package mec_pkg;
    localparam int APB_AW = 20;
    localparam int APB_DW = 32;
    localparam int RAM_AW = 11;
    localparam int RAM_DW = 8;
    localparam int RAM_CW = 5;
    localparam int FA_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PCFG = 16'hA00D;
    localparam logic [15:0] IDX_PADL = 16'hA00E;
    localparam logic [15:0] IDX_PADH = 16'hA00F;
    localparam logic [15:0] IDX_RCTL = 16'hA017;
    localparam logic [15:0] IDX_DCFG = 16'hA02D;
    localparam logic [15:0] IDX_DADL = 16'hA02E;
    localparam logic [15:0] IDX_DADH = 16'hA02F;
    localparam logic [APB_AW-1:0] ADDR_PCFG = {2'h0, IDX_PCFG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_PADL = {2'h0, IDX_PADL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_PADH = {2'h0, IDX_PADH, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_RCTL = {2'h0, IDX_RCTL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_DCFG = {2'h0, IDX_DCFG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_DADL = {2'h0, IDX_DADL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_DADH = {2'h0, IDX_DADH, 2'h0};

    // Configuration register fields, shared by data and program side
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_UIE_BIT = 5;
    localparam int CFG_CIE_BIT = 4;
    localparam int CFG_UF_BIT = 1;
    localparam int CFG_CF_BIT = 0;
    localparam int RCTL_EN_BIT = 6;
    localparam int RCTL_CLR_BIT = 4;
    localparam int RCTL_FLAG_BIT = 2;
    localparam logic [7:0] CFG_RST = 8'h80;
    localparam logic [FA_W-1:0] FAULT_RST = 16'h8000;

    // Syndrome column of each SRAM data bit and each nibble data bit
    localparam logic [7:0][3:0] SRAM_COL = {4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6, 4'h5, 4'h3};
    localparam logic [3:0][2:0] NIB_COL = {3'h7, 3'h6, 3'h5, 3'h3};

    typedef struct packed {
        logic req;
        logic we;
        logic [RAM_AW-1:0] addr;
        logic [RAM_DW-1:0] wdata;
    } mec_ram_req_type;

    typedef struct packed {
        logic en;
        logic we;
        logic [RAM_AW-1:0] addr;
        logic [RAM_DW+RAM_CW-1:0] wdata;
    } mec_mem_req_type;

    typedef struct packed {
        logic valid;
        logic [FA_W-1:0] addr;
        logic [15:0] word;
    } mec_fetch_type;

    typedef struct packed {
        logic [7:0] data;
        logic corr;
        logic uncorr;
    } mec_dec_type;

    function automatic logic [12:0] mec_sram_encode(input logic [7:0] d);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 8; j++) begin
                c[i] = c[i] ^ (d[j] & SRAM_COL[j][i]);
            end
        end
        c[4] = ^{d, c[3:0]};
        return {c, d};
    endfunction

    function automatic mec_dec_type mec_sram_decode(input logic [12:0] w);
        mec_dec_type r;
        logic [3:0] s;
        logic hit;
        logic [12:0] enc;
        r.data = w[7:0];
        r.corr = 1'b0;
        r.uncorr = 1'b0;
        hit = 1'b0;
        enc = mec_sram_encode(w[7:0]);
        s = enc[11:8] ^ w[11:8];
        if (^w) begin
            for (int j = 0; j < 8; j++) begin
                if (s == SRAM_COL[j]) begin
                    r.data[j] = ~w[j];
                    hit = 1'b1;
                end
            end
            // Single check-bit errors leave data intact
            if (hit || ((s & 4'(s - 4'h1)) == 4'h0)) begin
                r.corr = 1'b1;
            end else begin
                r.uncorr = 1'b1;
            end
        end else if (s != 4'h0) begin
            r.uncorr = 1'b1;
        end
        return r;
    endfunction
endpackage

// ---- hdl/mec_prog_dec.sv ----
module mec_prog_dec
    import mec_pkg::*;
(
    input wire logic [15:0] word, // Flash word, check bits high
    output mec_dec_type res // Corrected byte and error flags
);
    logic [1:0] nib_corr;
    logic [1:0] nib_uncorr;
    logic [7:0] data;

    // [RULE11] Per-nibble check code
    // [RULE12] Correct one, detect two per nibble
    for (genvar n = 0; n < 2; n++) begin : g_nib
        logic [3:0] d;
        logic [3:0] c;
        logic [2:0] s;
        logic [3:0] fix;
        assign d = word[4*n +: 4];
        assign c = word[8 + 4*n +: 4];
        assign s = {c[2] ^ d[1] ^ d[2] ^ d[3], c[1] ^ d[0] ^ d[2] ^ d[3],
                    c[0] ^ d[0] ^ d[1] ^ d[3]};
        for (genvar b = 0; b < 4; b++) begin : g_bit
            assign fix[b] = (^{d, c}) && (s == NIB_COL[b]);
        end
        assign data[4*n +: 4] = d ^ fix;
        assign nib_corr[n] = ^{d, c};
        assign nib_uncorr[n] = !(^{d, c}) && (s != 3'h0);
    end

    assign res.data = data;
    assign res.uncorr = |nib_uncorr;
    assign res.corr = (|nib_corr) && !(|nib_uncorr);
endmodule

// ---- hdl/mec_top.sv ----
// Summary of operation
// [RULE1] SRAM word is 13 bits: data byte plus five hardware check bits.
// [RULE2] SRAM checker corrects single-bit and detects double-bit errors per byte.
// [RULE3] Uncorrectable SRAM read latches address and requests interrupt.
// [RULE4] Correctable SRAM read returns corrected byte to the reader.
// [RULE5] SRAM uncorrectable flag, bit 1, set by hardware, cleared by software.
// [RULE6] SRAM correctable flag, bit 0, set by hardware, cleared by software.
// [RULE7] SRAM check enable at bit 7; data config resets to 0x80.
// [RULE8] Data config holds uncorrectable enable bit 5, correctable bit 4.
// [RULE9] SRAM fault address captured once, frozen while a flag stays set.
// [RULE10] Flash word: instruction in low byte, its check bits in high byte.
// [RULE11] High nibble of check bits guards high data nibble, low guards low.
// [RULE12] Each nibble code corrects one and detects two errors.
// [RULE13] Fetch checked in parallel; corrected byte passed; optional interrupt.
// [RULE14] Uncorrectable fetch raises interrupt or reset per configuration.
// [RULE15] Any fetch check error latches the fetch address.
// [RULE16] Program config bit 7 selects corrected or raw controller reads.
// [RULE17] Fetch uncorrectable flag, bit 1, sticky until software clears.
// [RULE18] Fetch correctable flag, bit 0, sticky until software clears.
// [RULE19] Program config holds uncorrectable enable bit 5, correctable bit 4.
// [RULE20] Software reinitialises SRAM after mode switch and after reset.
// [RULE21] Software rewrites corrected data after a correctable interrupt.
// [RULE22] Fetch error reset only when reset enable set; enable resets to zero.
// [RULE23] Check reset sets a flag cleared only by reset or clear write.
// [RULE24] Interrupt requests follow flag and matching enable both set; the fetch uncorrectable request is also masked while reset enable is set.
//
// Design decision made here: register access over APB.
module mec_top
    import mec_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [APB_AW-1:0] paddr, // APB byte address
    input wire logic [APB_DW-1:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [APB_DW-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input mec_ram_req_type ram_req, // CPU data memory request
    output logic [RAM_DW-1:0] ram_rdata, // Checked read byte
    output logic ram_rvalid, // Read byte valid
    output mec_mem_req_type mem_req, // Request to 13-bit SRAM
    input wire logic [RAM_DW+RAM_CW-1:0] mem_rdata, // SRAM word, one cycle after read
    input mec_fetch_type fetch, // Instruction fetch word
    output logic [7:0] fetch_byte, // Corrected instruction byte
    output logic fetch_byte_valid, // Instruction byte valid
    input wire logic fc_valid, // Flash controller read word valid
    input wire logic [15:0] fc_word, // Flash controller raw word
    output logic [15:0] fc_rdata, // Controller read result
    output logic fc_rvalid, // Controller read result valid
    output logic sram_irq, // SRAM error interrupt request
    output logic fetch_irq, // Fetch error interrupt request
    output logic ecc_reset_req // Reset request pulse on uncorrectable fetch
);
    typedef struct packed {
        logic d_en;
        logic d_uie;
        logic d_cie;
        logic d_uf;
        logic d_cf;
        logic [FA_W-1:0] d_addr;
        logic p_fc;
        logic p_uie;
        logic p_cie;
        logic p_uf;
        logic p_cf;
        logic [FA_W-1:0] p_addr;
        logic rst_en;
        logic rst_flag;
        logic rst_req;
        logic rd_pend;
        logic rd_chk;
        logic [RAM_AW-1:0] rd_addr;
        logic [RAM_DW-1:0] rdata;
        logic rvalid;
        logic [7:0] fbyte;
        logic fvalid;
        logic [15:0] fcdata;
        logic fcvalid;
        logic ready;
        logic [APB_DW-1:0] rd;
        logic err;
    } mec_state_type;

    localparam mec_state_type ST_RST = '{
        d_en: CFG_RST[CFG_EN_BIT],
        d_uie: CFG_RST[CFG_UIE_BIT],
        d_cie: CFG_RST[CFG_CIE_BIT],
        d_addr: FAULT_RST,
        p_fc: CFG_RST[CFG_EN_BIT],
        p_uie: CFG_RST[CFG_UIE_BIT],
        p_cie: CFG_RST[CFG_CIE_BIT],
        p_addr: FAULT_RST,
        default: '0
    };

    typedef enum logic [6:0] {
        SEL_NONE = 7'h00,
        SEL_PCFG = 7'h01,
        SEL_PADL = 7'h02,
        SEL_PADH = 7'h04,
        SEL_RCTL = 7'h08,
        SEL_DCFG = 7'h10,
        SEL_DADL = 7'h20,
        SEL_DADH = 7'h40
    } mec_sel_type;

    function automatic mec_sel_type reg_sel(input logic [APB_AW-1:0] a);
        mec_sel_type s;
        s = SEL_NONE;
        if (a == ADDR_PCFG) s = SEL_PCFG;
        if (a == ADDR_PADL) s = SEL_PADL;
        if (a == ADDR_PADH) s = SEL_PADH;
        if (a == ADDR_RCTL) s = SEL_RCTL;
        if (a == ADDR_DCFG) s = SEL_DCFG;
        if (a == ADDR_DADL) s = SEL_DADL;
        if (a == ADDR_DADH) s = SEL_DADH;
        return s;
    endfunction

    function automatic logic [7:0] cfg_byte(input logic en, input logic uie, input logic cie,
                                            input logic uf, input logic cf);
        logic [7:0] v;
        v = 8'h00;
        v[CFG_EN_BIT] = en;
        v[CFG_UIE_BIT] = uie;
        v[CFG_CIE_BIT] = cie;
        v[CFG_UF_BIT] = uf;
        v[CFG_CF_BIT] = cf;
        return v;
    endfunction

    mec_state_type st_q;
    mec_state_type st_d;
    mec_dec_type sram_res;
    mec_dec_type fetch_res;
    mec_dec_type fc_res;
    mec_sel_type sel;
    logic wr_fire;
    logic [7:0] wb;
    logic d_err;
    logic f_err;

    mec_prog_dec u_fetch_dec (
        .word(fetch.word),
        .res(fetch_res)
    );

    mec_prog_dec u_fc_dec (
        .word(fc_word),
        .res(fc_res)
    );

    // [RULE1] Encode on write, raw with zero check bits when disabled
    always_comb begin
        mem_req.en = ram_req.req;
        mem_req.we = ram_req.we;
        mem_req.addr = ram_req.addr;
        mem_req.wdata = st_q.d_en ? mec_sram_encode(ram_req.wdata) : {5'h00, ram_req.wdata};
    end

    // [RULE2] Decode the returned word
    assign sram_res = mec_sram_decode(mem_rdata);
    assign d_err = st_q.rd_pend && st_q.rd_chk && (sram_res.corr || sram_res.uncorr);
    assign f_err = fetch.valid && (fetch_res.corr || fetch_res.uncorr);
    assign sel = reg_sel(paddr);
    assign wr_fire = psel && penable && pwrite && st_q.ready && pstrb[0];
    assign wb = pwdata[7:0];

    always_comb begin
        st_d = st_q;
        st_d.rst_req = 1'b0;

        // SRAM read return
        st_d.rd_pend = ram_req.req && !ram_req.we;
        st_d.rd_addr = ram_req.addr;
        st_d.rd_chk = st_q.d_en;
        st_d.rvalid = st_q.rd_pend;
        if (st_q.rd_pend) begin
            // [RULE4] Corrected byte to reader
            st_d.rdata = st_q.rd_chk ? sram_res.data : mem_rdata[7:0];
        end

        // Software side of the configuration registers
        if (wr_fire && sel == SEL_DCFG) begin
            st_d.d_en = wb[CFG_EN_BIT];
            // [RULE8] Data interrupt enables
            st_d.d_uie = wb[CFG_UIE_BIT];
            st_d.d_cie = wb[CFG_CIE_BIT];
            st_d.d_uf = st_q.d_uf && wb[CFG_UF_BIT];
            st_d.d_cf = st_q.d_cf && wb[CFG_CF_BIT];
        end
        if (wr_fire && sel == SEL_PCFG) begin
            // [RULE16] Controller read select
            st_d.p_fc = wb[CFG_EN_BIT];
            // [RULE19] Program interrupt enables
            st_d.p_uie = wb[CFG_UIE_BIT];
            st_d.p_cie = wb[CFG_CIE_BIT];
            st_d.p_uf = st_q.p_uf && wb[CFG_UF_BIT];
            st_d.p_cf = st_q.p_cf && wb[CFG_CF_BIT];
        end
        if (wr_fire && sel == SEL_RCTL) begin
            st_d.rst_en = wb[RCTL_EN_BIT];
            if (wb[RCTL_CLR_BIT]) begin
                st_d.rst_flag = 1'b0;
            end
        end

        // [RULE9] Capture only while both flags clear
        if (d_err && !st_q.d_uf && !st_q.d_cf) begin
            st_d.d_addr = {{(FA_W - RAM_AW){1'b0}}, st_q.rd_addr};
        end
        // [RULE3] Uncorrectable read flags, set wins
        // [RULE5] Sticky uncorrectable flag
        if (d_err && sram_res.uncorr) begin
            st_d.d_uf = 1'b1;
        end
        // [RULE6] Sticky correctable flag
        if (d_err && sram_res.corr) begin
            st_d.d_cf = 1'b1;
        end

        // [RULE10] Low byte is the instruction
        // [RULE13] Corrected byte to the CPU
        st_d.fvalid = fetch.valid;
        if (fetch.valid) begin
            st_d.fbyte = fetch_res.data;
        end
        // [RULE15] Latch failing fetch address
        if (f_err) begin
            st_d.p_addr = fetch.addr;
        end
        // [RULE17] Sticky fetch uncorrectable flag
        if (fetch.valid && fetch_res.uncorr) begin
            st_d.p_uf = 1'b1;
        end
        // [RULE18] Sticky fetch correctable flag
        if (fetch.valid && fetch_res.corr) begin
            st_d.p_cf = 1'b1;
        end
        // [RULE22] Reset only when enabled
        // [RULE23] Flag set wins over clear
        if (fetch.valid && fetch_res.uncorr && st_q.rst_en) begin
            st_d.rst_req = 1'b1;
            st_d.rst_flag = 1'b1;
        end

        // [RULE16] Corrected or raw controller read
        st_d.fcvalid = fc_valid;
        if (fc_valid) begin
            st_d.fcdata = st_q.p_fc ? {fc_word[15:8], fc_res.data} : fc_word;
        end

        // APB: one wait state; read data sampled in the first access cycle, write data in the second
        st_d.ready = psel && penable && !st_q.ready;
        if (psel && penable && !st_q.ready) begin
            st_d.err = (sel == SEL_NONE);
            st_d.rd = '0;
            unique case (sel)
                SEL_PCFG: st_d.rd[7:0] = cfg_byte(st_q.p_fc, st_q.p_uie, st_q.p_cie,
                                                  st_q.p_uf, st_q.p_cf);
                SEL_PADL: st_d.rd[7:0] = st_q.p_addr[7:0];
                SEL_PADH: st_d.rd[7:0] = st_q.p_addr[15:8];
                SEL_RCTL: begin
                    st_d.rd[RCTL_EN_BIT] = st_q.rst_en;
                    st_d.rd[RCTL_FLAG_BIT] = st_q.rst_flag;
                end
                SEL_DCFG: st_d.rd[7:0] = cfg_byte(st_q.d_en, st_q.d_uie, st_q.d_cie,
                                                  st_q.d_uf, st_q.d_cf);
                SEL_DADL: st_d.rd[7:0] = st_q.d_addr[7:0];
                SEL_DADH: st_d.rd[7:0] = st_q.d_addr[15:8];
                default: st_d.rd = '0;
            endcase
        end
    end

    // [RULE7] Checking on after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rd;
    assign pready = st_q.ready;
    assign pslverr = st_q.ready && st_q.err;
    assign ram_rdata = st_q.rdata;
    assign ram_rvalid = st_q.rvalid;
    assign fetch_byte = st_q.fbyte;
    assign fetch_byte_valid = st_q.fvalid;
    assign fc_rdata = st_q.fcdata;
    assign fc_rvalid = st_q.fcvalid;
    assign ecc_reset_req = st_q.rst_req;
    // [RULE24] Flag and enable gate the request
    // [RULE14] Reset replaces the uncorrectable interrupt
    assign sram_irq = (st_q.d_uf && st_q.d_uie) || (st_q.d_cf && st_q.d_cie);
    assign fetch_irq = (st_q.p_uf && st_q.p_uie && !st_q.rst_en) || (st_q.p_cf && st_q.p_cie);

    property p_sram_uncorr;
        @(posedge clk) disable iff (sys_rst)
        d_err && sram_res.uncorr |=> st_q.d_uf && ram_rvalid ##1 st_q.d_uf || !$past(wr_fire);
    endproperty
    a_sram_uncorr: assert property (p_sram_uncorr) else $error("uncorr flag missed"); // [RULE5]

    property p_sram_corr;
        @(posedge clk) disable iff (sys_rst)
        d_err && sram_res.corr |=> st_q.d_cf && (ram_rdata == $past(sram_res.data));
    endproperty
    a_sram_corr: assert property (p_sram_corr) else $error("corr flag or data wrong"); // [RULE4]

    property p_addr_hold;
        @(posedge clk) disable iff (sys_rst)
        (st_q.d_uf || st_q.d_cf) |=> $stable(st_q.d_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("fault address overwritten"); // [RULE9]

    property p_addr_cap;
        @(posedge clk) disable iff (sys_rst)
        d_err && !st_q.d_uf && !st_q.d_cf |=> st_q.d_addr[RAM_AW-1:0] == $past(st_q.rd_addr);
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("fault address not captured"); // [RULE3]

    property p_fetch_pass;
        @(posedge clk) disable iff (sys_rst)
        fetch.valid && !fetch_res.uncorr |=> fetch_byte_valid && fetch_byte == $past(fetch_res.data);
    endproperty
    a_fetch_pass: assert property (p_fetch_pass) else $error("fetch byte not passed"); // [RULE13]

    property p_fetch_addr;
        @(posedge clk) disable iff (sys_rst)
        f_err |=> st_q.p_addr == $past(fetch.addr) && (st_q.p_uf || st_q.p_cf);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch addr wrong"); // [RULE15]

    property p_rst_gate;
        @(posedge clk) disable iff (sys_rst)
        ecc_reset_req |-> $past(st_q.rst_en) && st_q.rst_flag && st_q.p_uf;
    endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("reset without enable"); // [RULE22]

    property p_rst_flag;
        @(posedge clk) disable iff (sys_rst)
        st_q.rst_flag && !(wr_fire && sel == SEL_RCTL) |=> st_q.rst_flag;
    endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("reset flag lost"); // [RULE23]

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        st_q.d_uf && st_q.d_uie |-> sram_irq ##1 (sram_irq || !st_q.d_uf || !st_q.d_uie);
    endproperty
    a_irq: assert property (p_irq) else $error("sram irq not raised"); // [RULE24]

    property p_fc_raw;
        @(posedge clk) disable iff (sys_rst)
        fc_valid && !st_q.p_fc |=> fc_rvalid && fc_rdata == $past(fc_word);
    endproperty
    a_fc_raw: assert property (p_fc_raw) else $error("controller raw read altered"); // [RULE16]

    property p_apb_wait;
        @(posedge clk) disable iff (sys_rst)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");

    c_sram_corr: cover property (@(posedge clk) disable iff (sys_rst) d_err && sram_res.corr);
    c_fetch_rst: cover property (@(posedge clk) disable iff (sys_rst) ecc_reset_req);
    c_fetch_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(fetch_irq));
    c_cfg_write: cover property (@(posedge clk) disable iff (sys_rst) wr_fire && sel == SEL_DCFG);
endmodule

// ---- sim/mec_sram_model.sv ----
module mec_sram_model
    import mec_pkg::*;
(
    input wire logic clk, // System clock
    input mec_mem_req_type mem_req, // Request from checker
    input wire logic [12:0] flip, // Error injection mask
    output logic [12:0] mem_rdata // Read word, one cycle later
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [12:0] mem_q [0:2047];
    initial mem_rdata = 13'h0000;
    always @(posedge clk) begin
        if (mem_req.en && mem_req.we) begin
            mem_q[mem_req.addr] <= mem_req.wdata;
        end
        // Any cycle without a read, writes included, inverts the previous word
        if (mem_req.en && !mem_req.we) begin
            mem_rdata <= mem_q[mem_req.addr] ^ flip;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ---- sim/tb_mec_top.sv ----
module tb_mec_top
    import mec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, ram_rvalid, fetch_byte_valid, fc_rvalid, sram_irq, fetch_irq;
    logic ecc_reset_req, fc_valid = 1'b0;
    mec_ram_req_type ram_req = '0;
    mec_fetch_type fetch = '0;
    mec_mem_req_type mem_req;
    logic [7:0] ram_rdata, fetch_byte, q;
    logic [12:0] mem_rdata, flip = 13'h0000;
    logic [15:0] fc_word = 16'h0000, fc_rdata;
    int n_errors = 0, checks_done = 0, cyc = 0;

    mec_top u_mec_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ram_req(ram_req), .ram_rdata(ram_rdata),
        .ram_rvalid(ram_rvalid), .mem_req(mem_req), .mem_rdata(mem_rdata), .fetch(fetch),
        .fetch_byte(fetch_byte), .fetch_byte_valid(fetch_byte_valid), .fc_valid(fc_valid),
        .fc_word(fc_word), .fc_rdata(fc_rdata), .fc_rvalid(fc_rvalid), .sram_irq(sram_irq),
        .fetch_irq(fetch_irq), .ecc_reset_req(ecc_reset_req));
    mec_sram_model u_mec_sram_model (.clk(clk), .mem_req(mem_req), .flip(flip),
        .mem_rdata(mem_rdata));

    always #12.5 clk = ~clk;

    function automatic logic [12:0] enc13(input logic [7:0] d);
        logic [3:0] col [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
        logic [3:0] c = 4'h0;
        for (int j = 0; j < 8; j++) if (d[j]) c = c ^ col[j];
        return {^{d, c}, c, d};
    endfunction
    function automatic logic [3:0] enc4(input logic [3:0] d);
        logic [2:0] c = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
        return {^{d, c}, c};
    endfunction
    function automatic logic [15:0] fw(input logic [7:0] b);
        return {enc4(b[7:4]), enc4(b[3:0]), b};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
        checks_done++;
        if (s !== x) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input string n, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(n, q, x);
    endtask
    task automatic sram(input logic w, input logic [10:0] a, input logic [7:0] d, input bit ck);
        @(posedge clk);
        ram_req <= {1'b1, w, a, d};
        @(negedge clk);
        if (w) chk("mem_wdata", mem_req.wdata, enc13(d));
        @(posedge clk);
        ram_req.req <= 1'b0;
        if (!w) begin
            @(posedge clk);
            @(negedge clk);
            chk("ram_rvalid", ram_rvalid, 1'b1);
            if (ck) chk("ram_rdata", ram_rdata, d);
        end
    endtask
    task automatic fe(input logic [15:0] a, input logic [15:0] wd, input logic [7:0] x,
            input bit ck, input logic r);
        @(posedge clk);
        fetch <= {1'b1, a, wd};
        @(posedge clk);
        fetch.valid <= 1'b0;
        @(negedge clk);
        chk("fetch_valid", fetch_byte_valid, 1'b1);
        if (ck) chk("fetch_byte", fetch_byte, x);
        chk("reset_req", ecc_reset_req, r);
    endtask
    task automatic fc(input logic [15:0] wd, input logic [15:0] x);
        @(posedge clk);
        fc_valid <= 1'b1;
        fc_word <= wd;
        @(posedge clk);
        fc_valid <= 1'b0;
        @(negedge clk);
        chk("fc_rvalid", fc_rvalid, 1'b1);
        chk("fc_rdata", fc_rdata, x);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(ADDR_DCFG, "dcfg", 8'h80);
        rd(ADDR_DADL, "dadl", 8'h00);
        rd(ADDR_DADH, "dadh", 8'h80);
        rd(ADDR_PCFG, "pcfg", 8'h80);
        rd(ADDR_RCTL, "rctl", 8'h00);
        rd(20'h00000, "unmapped", 8'h00);
        chk("pslverr", e, 1'b1);
        $display("reset test done");
        apb(1'b1, ADDR_DCFG, 8'hB0);
        sram(1'b1, 11'h123, 8'hA5, 1);
        sram(1'b0, 11'h123, 8'hA5, 1);
        rd(ADDR_DCFG, "dcfg", 8'hB0);
        flip <= 13'h0008;
        sram(1'b0, 11'h123, 8'hA5, 1);
        rd(ADDR_DCFG, "dcfg", 8'hB1);
        chk("sram_irq", sram_irq, 1'b1);
        rd(ADDR_DADL, "dadl", 8'h23);
        rd(ADDR_DADH, "dadh", 8'h01);
        flip <= 13'h0000;
        sram(1'b1, 11'h123, 8'hA5, 1);
        sram(1'b1, 11'h045, 8'h3C, 1);
        flip <= 13'h0003;
        sram(1'b0, 11'h045, 8'h00, 0);
        rd(ADDR_DCFG, "dcfg", 8'hB3);
        rd(ADDR_DADL, "dadl", 8'h23);
        flip <= 13'h0200;
        sram(1'b0, 11'h123, 8'hA5, 1);
        flip <= 13'h0000;
        apb(1'b1, ADDR_DCFG, 8'hB0);
        rd(ADDR_DCFG, "dcfg", 8'hB0);
        chk("sram_irq", sram_irq, 1'b0);
        $display("sram test done");
        apb(1'b1, ADDR_PCFG, 8'hB0);
        fe(16'h1234, fw(8'h5A) ^ 16'h0011, 8'h5A, 1, 1'b0);
        rd(ADDR_PCFG, "pcfg", 8'hB1);
        chk("fetch_irq", fetch_irq, 1'b1);
        rd(ADDR_PADL, "padl", 8'h34);
        rd(ADDR_PADH, "padh", 8'h12);
        fe(16'h2345, fw(8'h5A) ^ 16'h0003, 8'h00, 0, 1'b0);
        rd(ADDR_PCFG, "pcfg", 8'hB3);
        rd(ADDR_PADL, "padl", 8'h45);
        fe(16'h0010, fw(8'hC3) ^ 16'h1000, 8'hC3, 1, 1'b0);
        apb(1'b1, ADDR_PCFG, 8'hB0);
        fe(16'h0200, fw(8'h5A) ^ 16'h0030, 8'h00, 0, 1'b0);
        chk("fetch_irq", fetch_irq, 1'b1);
        rd(ADDR_PCFG, "pcfg", 8'hB2);
        apb(1'b1, ADDR_PCFG, 8'hB0);
        apb(1'b1, ADDR_RCTL, 8'h40);
        fe(16'h0100, fw(8'h5A) ^ 16'h0030, 8'h00, 0, 1'b1);
        rd(ADDR_RCTL, "rctl", 8'h44);
        chk("fetch_irq", fetch_irq, 1'b0);
        apb(1'b1, ADDR_RCTL, 8'h50);
        rd(ADDR_RCTL, "rctl", 8'h40);
        $display("fetch test done");
        apb(1'b1, ADDR_PCFG, 8'h80);
        fc(fw(8'hA5) ^ 16'h1001, fw(8'hA5) ^ 16'h1000);
        apb(1'b1, ADDR_PCFG, 8'h00);
        fc(fw(8'hA5) ^ 16'h1001, fw(8'hA5) ^ 16'h1001);
        $display("flash read test done");
        print_verdict();
    end
endmodule
